// ===== design/rail_strobe_assignment_regs.sv
// Summary of operation
// - backup converter b selector in bits 5:4; 1h strobe 1, 2h strobe 2
// - backup converter a selector in bits 1:0, same coding as converter b
// - strobes 1 and 2 act only while the freshness seal flag is 0
// - wide selectors decode 3h..Ah as strobes 3..10, else unsequenced
// - register 25h resets 63h: switch selector 7:4, regulator selector 3:0
// - register 24h resets 12h; bits 7:6 and 3:2 read zero, not writable
//
// register slice of the power-up sequencer: strobe slot assignment for four rails
// assumes requests synchronous to CLK, unlock pulse from the password checker
`timescale 1ns/1ps
`include "strobe_sel_map.svh"

module rail_strobe_assignment_regs (
  input  wire logic                      CLK,
  input  wire logic                      RST,
  input  wire logic                      CE,
  input  wire strobe_sel_pkg::reg_req_t  REQ,
  input  wire logic                      UNLOCK_OK,
  input  wire logic                      FRESHNESS_SEAL_FLAG,
  input  wire logic                      POWER_DOWN,
  output logic      [7:0]                RDATA,
  output logic                           WR_ACCEPTED,
  output logic      [9:0]                BACKUP_A_SLOTS,
  output logic      [9:0]                BACKUP_B_SLOTS,
  output logic      [9:0]                LINEAR_REG_SLOTS,
  output logic      [9:0]                SWITCH_SLOTS,
  output logic                           BACKUP_A_OFF_ALLOWED,
  output logic                           BACKUP_B_OFF_ALLOWED
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    strobe_sel_pkg::sel_fields_t sel;
    strobe_sel_pkg::lock_state_t lock;
    logic [7:0]                  rdata;
    logic                        accepted;
  } state_t;

  state_t state_ff;
  state_t nxt_state;
  logic   early_ok;
  logic   hit_backup;
  logic   hit_reg_sw;

  function automatic logic [7:0] read_mux(input logic [7:0] addr,
                                         input strobe_sel_pkg::sel_fields_t s);
    read_mux = 8'h00;
    if (addr == `BACKUP_SEL_ADDR) begin
      // reserved bits stay zero by construction
      read_mux = {2'b00, s.backup_b, 2'b00, s.backup_a};
    end else if (addr == `REG_SW_SEL_ADDR) begin
      read_mux = {s.low_volt_switch, s.linear_reg};
    end
  endfunction

  assign hit_backup = REQ.addr == `BACKUP_SEL_ADDR;
  assign hit_reg_sw = REQ.addr == `REG_SW_SEL_ADDR;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state          = state_ff;
    nxt_state.accepted = 1'b0;
    case (state_ff.lock)
      strobe_sel_pkg::ST_IDLE: begin
        if (UNLOCK_OK) begin
          nxt_state.lock = strobe_sel_pkg::ST_UNLOCKED;
        end
      end
      strobe_sel_pkg::ST_UNLOCKED: begin
        // any write relocks, so each write needs a fresh unlock
        if (REQ.wr_en) begin
          nxt_state.lock = strobe_sel_pkg::ST_IDLE;
          if (hit_backup) begin
            nxt_state.sel.backup_b = REQ.wdata[`BACKUP_B_LSB +: 2];
            nxt_state.sel.backup_a = REQ.wdata[`BACKUP_A_LSB +: 2];
            nxt_state.accepted     = 1'b1;
          end else if (hit_reg_sw) begin
            nxt_state.sel.low_volt_switch = REQ.wdata[`SWITCH_LSB +: 4];
            nxt_state.sel.linear_reg      = REQ.wdata[`LINREG_LSB +: 4];
            nxt_state.accepted            = 1'b1;
          end
        end
      end
      default: begin
        nxt_state.lock = strobe_sel_pkg::ST_IDLE;
      end
    endcase
    if (REQ.rd_en) begin
      nxt_state.rdata = read_mux(REQ.addr, state_ff.sel);
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_ff.sel.backup_b        <= `BACKUP_B_RESET;
      state_ff.sel.backup_a        <= `BACKUP_A_RESET;
      state_ff.sel.low_volt_switch <= `SWITCH_RESET;
      state_ff.sel.linear_reg      <= `LINREG_RESET;
      state_ff.lock                <= strobe_sel_pkg::ST_IDLE;
      state_ff.rdata               <= 8'h00;
      state_ff.accepted            <= 1'b0;
    end else if (CE) begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // strobe slot decode
  // ----------------------------------------------------------------
  assign early_ok = ~FRESHNESS_SEAL_FLAG;

  strobe_slot_decode #(.SEL_W(2)) u_dec_a (
    .sel      (state_ff.sel.backup_a),
    .early_ok (early_ok),
    .slot     (BACKUP_A_SLOTS)
  );

  strobe_slot_decode #(.SEL_W(2)) u_dec_b (
    .sel      (state_ff.sel.backup_b),
    .early_ok (early_ok),
    .slot     (BACKUP_B_SLOTS)
  );

  strobe_slot_decode #(.SEL_W(4)) u_dec_l (
    .sel      (state_ff.sel.linear_reg),
    .early_ok (1'b1),
    .slot     (LINEAR_REG_SLOTS)
  );

  strobe_slot_decode #(.SEL_W(4)) u_dec_s (
    .sel      (state_ff.sel.low_volt_switch),
    .early_ok (1'b1),
    .slot     (SWITCH_SLOTS)
  );

  // broken seal: backup rails stay on through power-down regardless of selector
  assign BACKUP_A_OFF_ALLOWED = POWER_DOWN & ~FRESHNESS_SEAL_FLAG
                                & (BACKUP_A_SLOTS != 10'h000);
  assign BACKUP_B_OFF_ALLOWED = POWER_DOWN & ~FRESHNESS_SEAL_FLAG
                                & (BACKUP_B_SLOTS != 10'h000);

  assign RDATA       = state_ff.rdata;
  assign WR_ACCEPTED = state_ff.accepted;

endmodule

// ===== design/strobe_sel_map.svh
// register offsets, field positions, reset values for the rail strobe assignment slice
// assumes inclusion by bare name from the package and design files
`ifndef STROBE_SEL_MAP_SVH
`define STROBE_SEL_MAP_SVH

`define BACKUP_SEL_ADDR        8'h24
`define REG_SW_SEL_ADDR        8'h25
`define BACKUP_SEL_RESET       8'h12
`define REG_SW_SEL_RESET       8'h63
`define BACKUP_SEL_WMASK       8'h33
`define BACKUP_B_LSB           4
`define BACKUP_A_LSB           0
`define SWITCH_LSB             4
`define LINREG_LSB             0
`define BACKUP_B_RESET         2'h1
`define BACKUP_A_RESET         2'h2
`define SWITCH_RESET           4'h6
`define LINREG_RESET           4'h3
`define WIDE_FIRST_CODE        4'h3
`define WIDE_LAST_CODE         4'hA
`define WIDE_STROBE_OFFSET     4'h0
`define STROBE_COUNT           10

`endif

// ===== design/strobe_sel_pkg.sv
// types shared by the strobe assignment registers, the bench and the checker
// assumes the map header sits beside it
`include "strobe_sel_map.svh"

package strobe_sel_pkg;

  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [1:0] backup_b;
    logic [1:0] backup_a;
    logic [3:0] low_volt_switch;
    logic [3:0] linear_reg;
  } sel_fields_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_UNLOCKED
  } lock_state_t;

endpackage

// ===== design/strobe_slot_decode.sv
// decodes one strobe selector field into a one-hot strobe slot vector
// assumes selectors are stable register outputs; purely combinational
`timescale 1ns/1ps
`include "strobe_sel_map.svh"

module strobe_slot_decode #(
  parameter int SEL_W = 4
) (
  input  wire logic [SEL_W-1:0] sel,
  input  wire logic             early_ok,
  output logic      [9:0]       slot
);

  initial begin
    if (SEL_W != 2 && SEL_W != 4) begin
      $error("strobe selector width must be 2 or 4");
    end
  end

  always_comb begin
    slot = 10'h000;
    if (SEL_W == 2) begin
      // narrow field: 1h, 2h pick strobes 1 and 2, others unsequenced
      if (sel == 1 && early_ok) begin
        slot[0] = 1'b1;
      end else if (sel == 2 && early_ok) begin
        slot[1] = 1'b1;
      end
    end else begin
      if (sel >= `WIDE_FIRST_CODE && sel <= `WIDE_LAST_CODE) begin
        slot[sel - 1] = 1'b1;
      end
    end
  end

endmodule

// ===== test/rail_strobe_assignment_regs_bench.sv
// bench for the rail strobe assignment slice
// assumes the bench drives every port itself, 5 to 15 ns after each edge
`timescale 1ns/1ps
module rail_strobe_assignment_regs_bench;
  logic CLK = 0, RST = 1, CE = 1, UNLOCK_OK = 0, FRESHNESS_SEAL_FLAG = 0, POWER_DOWN = 0;
  strobe_sel_pkg::reg_req_t REQ = '0;
  logic [7:0] RDATA;
  logic WR_ACCEPTED, BACKUP_A_OFF_ALLOWED, BACKUP_B_OFF_ALLOWED;
  logic [9:0] BACKUP_A_SLOTS, BACKUP_B_SLOTS, LINEAR_REG_SLOTS, SWITCH_SLOTS;
  int n_fail = 0, samples_checked = 0;
  rail_strobe_assignment_regs i_dut (.*);
  initial forever #25 CLK = ~CLK;
  // ----------------
  // shared tasks
  // ----------------
  task automatic complete_run();
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(string n, logic [9:0] e, logic [9:0] s);
    samples_checked++;
    if (s !== e) begin
      $display("BAD %s exp %h got %h", n, e, s);
      n_fail++;
    end
  endtask
  task automatic cyc();
    @(posedge CLK);
    #5;
  endtask
  // unlock pulse one edge ahead, then the write; u=0 leaves it locked
  task automatic wr(logic [7:0] a, logic [7:0] d, logic u);
    UNLOCK_OK = u;
    cyc();
    UNLOCK_OK = 0;
    REQ = '{1'h1, 1'h0, a, d};
    cyc();
    REQ = '0;
    chk("accepted", {9'h000, u}, {9'h000, WR_ACCEPTED});
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    REQ = '{1'h0, 1'h1, a, 8'h00};
    cyc();
    REQ = '0;
    chk("rdata", {2'h0, e}, {2'h0, RDATA});
  endtask
  // ----------------
  // scenarios
  // ----------------
  task automatic t_reset();
    rd(8'h24, 8'h12);
    rd(8'h25, 8'h63);
    rd(8'h30, 8'h00);
    wr(8'h25, 8'h00, 1'h0);
    rd(8'h25, 8'h63);
  endtask
  task automatic t_wide();
    logic [3:0] v;
    logic [9:0] e;
    for (int c = 0; c < 16; c++) begin
      v = c[3:0];
      e = (c >= 3 && c <= 10) ? 10'h001 << (c - 1) : 10'h000;
      wr(8'h25, {v, v}, 1'h1);
      chk("linreg", e, LINEAR_REG_SLOTS);
      chk("switch", e, SWITCH_SLOTS);
      rd(8'h25, {v, v});
    end
  endtask
  // clock enable low: unlock and write must both be lost, register keeps FFh
  task automatic t_freeze();
    CE = 0;
    UNLOCK_OK = 1;
    cyc();
    UNLOCK_OK = 0;
    REQ = '{1'h1, 1'h0, 8'h25, 8'h00};
    cyc();
    REQ = '0;
    chk("frozen_acc", 10'h000, {9'h000, WR_ACCEPTED});
    CE = 1;
    cyc();
    rd(8'h25, 8'hFF);
  endtask
  task automatic t_backup();
    logic [1:0] v;
    logic [9:0] e;
    for (int c = 0; c < 4; c++) begin
      v = c[1:0];
      e = (c == 1) ? 10'h001 : (c == 2) ? 10'h002 : 10'h000;
      wr(8'h24, {2'h3, v, 2'h3, v}, 1'h1);
      rd(8'h24, {2'h0, v, 2'h0, v});
      chk("slot_a", e, BACKUP_A_SLOTS);
      chk("slot_b", e, BACKUP_B_SLOTS);
      POWER_DOWN = 1;
      #5 chk("off_a", {9'h000, |e}, {9'h000, BACKUP_A_OFF_ALLOWED});
      FRESHNESS_SEAL_FLAG = 1;
      #5 chk("sealed_a", 10'h000, BACKUP_A_SLOTS);
      chk("sealed_off", 10'h000, {8'h00, BACKUP_A_OFF_ALLOWED, BACKUP_B_OFF_ALLOWED});
      FRESHNESS_SEAL_FLAG = 0;
      POWER_DOWN = 0;
    end
  endtask
  initial begin
    repeat (3) @(posedge CLK);
    #5 RST = 0;
    t_reset();
    t_wide();
    t_freeze();
    t_backup();
    complete_run();
  end
  initial begin
    #200000;
    n_fail++;
    complete_run();
  end
endmodule
bind rail_strobe_assignment_regs rail_strobe_sva i_sva (.*);

// ===== test/rail_strobe_sva.sv
// checker for the rail strobe assignment slice
// assumes bind from the bench top; one clock domain
`timescale 1ns/1ps
module rail_strobe_sva (
  input wire logic                     CLK,
  input wire logic                     RST,
  input wire logic                     CE,
  input wire strobe_sel_pkg::reg_req_t REQ,
  input wire logic                     FRESHNESS_SEAL_FLAG,
  input wire logic                     POWER_DOWN,
  input wire logic [7:0]               RDATA,
  input wire logic                     WR_ACCEPTED,
  input wire logic [9:0]               BACKUP_A_SLOTS,
  input wire logic [9:0]               BACKUP_B_SLOTS,
  input wire logic [9:0]               LINEAR_REG_SLOTS,
  input wire logic [9:0]               SWITCH_SLOTS,
  input wire logic                     BACKUP_A_OFF_ALLOWED,
  input wire logic                     BACKUP_B_OFF_ALLOWED
);
  // ----------------
  // assertions
  // ----------------
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  seal_skip_a: assert property (FRESHNESS_SEAL_FLAG |-> (BACKUP_A_SLOTS | BACKUP_B_SLOTS) == 0)
    else $error("backup slot active with seal broken");
  a_early_a: assert property ($onehot0(BACKUP_A_SLOTS) && BACKUP_A_SLOTS[9:2] == 0)
    else $error("converter a slot out of range");
  b_early_a: assert property ($onehot0(BACKUP_B_SLOTS) && BACKUP_B_SLOTS[9:2] == 0)
    else $error("converter b slot out of range");
  linreg_range_a: assert property ($onehot0(LINEAR_REG_SLOTS) && !LINEAR_REG_SLOTS[1:0])
    else $error("regulator slot out of range");
  switch_range_a: assert property ($onehot0(SWITCH_SLOTS) && !SWITCH_SLOTS[1:0])
    else $error("switch slot out of range");
  keep_on_a: assert property (FRESHNESS_SEAL_FLAG || !POWER_DOWN |->
    !BACKUP_A_OFF_ALLOWED && !BACKUP_B_OFF_ALLOWED) else $error("backup turn-off allowed");
  wr_cause_a: assert property (WR_ACCEPTED |-> $past(REQ.wr_en && CE))
    else $error("write accepted without request");
  rd_hold_a: assert property (!$past(REQ.rd_en && CE) |-> $stable(RDATA))
    else $error("read data moved without read");
  rsvd_zero_a: assert property ($past(REQ.rd_en && CE && REQ.addr == 8'h24) |->
    RDATA[7:6] == 0 && RDATA[3:2] == 0) else $error("reserved bits read nonzero");
  cover property (WR_ACCEPTED);
  cover property (FRESHNESS_SEAL_FLAG && POWER_DOWN);
  cover property (BACKUP_A_OFF_ALLOWED);
endmodule
